// ===== rtl/iusu_pkg.sv
// constants, state types and register map of the serial unit
package iusu_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TBUF_STD_NS = 4700;
  localparam int TBUF_FAST_NS = 1300;
  localparam int QTR_STD_NS = 2500;
  localparam int QTR_FAST_NS = 625;
  localparam logic [7:0] TBUF_STD_CYC = 8'((TBUF_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] TBUF_FAST_CYC = 8'((TBUF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] QTR_STD_CYC = 8'((QTR_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] QTR_FAST_CYC = 8'((QTR_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [19:0] BRK_MIN_CYC = 20'h00800;
  localparam logic [19:0] AB_RND16 = 20'h00040;
  localparam logic [19:0] AB_RND1 = 20'h00004;
  localparam int AB_SH16 = 7;
  localparam int AB_SH1 = 3;
  localparam logic [3:0] FRAME_LAST = 4'hA;
  localparam logic [3:0] BRK_LAST = 4'hC;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_ADDR = 6'h04;
  localparam logic [5:0] REG_I2C_DATA = 6'h08;
  localparam logic [5:0] REG_UART_DATA = 6'h0C;
  localparam logic [5:0] REG_STATUS = 6'h10;
  localparam logic [5:0] REG_MASK = 6'h14;
  localparam logic [5:0] REG_STATE = 6'h18;
  localparam logic [5:0] REG_BAUD = 6'h1C;
  localparam int C_START = 0, C_STOP = 1, C_TEN = 2, C_RX = 3, C_FAST = 4;
  localparam int C_BRK = 5, C_OS16 = 6, C_AB = 7, C_HOLD = 8;
  localparam int F_TX = 0, F_RX = 1, F_STOP = 2, F_START = 3, F_NACK = 4, F_BRK = 5, F_UTX = 6;
  localparam logic [6:0] FLAGS_RST = 7'h40;
  localparam logic [15:0] BAUD_RST = 16'h0008;
  localparam logic [2:0] SYNC_RST = 3'h7;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [2:0] {I_IDLE, I_START, I_BYTE, I_HOLD, I_STOP} iusu_i2c_e;
  typedef enum logic [1:0] {SEQ_A1, SEQ_A2, SEQ_DATA} iusu_seq_e;
  typedef enum logic [1:0] {U_IDLE, U_DATA, U_BREAK} iusu_utx_e;
  typedef enum logic [1:0] {A_IDLE, A_LOW, A_HIGH, A_SYNC} iusu_ab_e;
  typedef struct packed {
    logic ack; logic [31:0] rdata; logic [8:0] ctl; logic [9:0] saddr;
    logic [7:0] i2c_tx; logic tx_loaded; logic [7:0] uart_tx; logic utx_loaded;
    logic [6:0] flags; logic [6:0] mask; logic [7:0] rxdata; logic [15:0] baud;
    logic [2:0] scl_s; logic [2:0] sda_s; logic [2:0] rxd_s;
    logic bus_busy; logic [7:0] free_cnt;
    iusu_i2c_e ist; iusu_seq_e seq; logic [7:0] qcnt; logic [1:0] ph; logic [3:0] bitn;
    logic [7:0] sh; logic ackb; logic scl_low; logic sda_low; logic nack_pend; logic fall_pend;
    iusu_utx_e ust; logic [19:0] ucnt; logic [3:0] ubit; logic [10:0] ush; logic txd;
    iusu_ab_e ab; logic [19:0] acnt; logic [2:0] aedge;
  } iusu_state_s;
endpackage

// ===== rtl/iusu_serial_unit.sv
// two-wire bus master and uart with break and automatic baud detection
`timescale 1ns/1ns
// Contract
// RULE1 - ten-bit address goes out as two bytes, second only after first is acked
// RULE2 - after repeated start, second address byte is sent before any receive
// RULE3 - software requests stop after a ten-bit address nack, not repeated start
// RULE4 - break requested mid-character waits until that stop bit went out high
// RULE5 - software sets send-break only while the uart is idle
// RULE6 - measured divider is written to both divider bytes
// RULE7 - with sixteen-times oversampling a divider of two reads as 0x0002
// RULE8 - detected break and synch field sets the break-seen flag
// RULE9 - nack with start requested and stop not requested clears transmit-empty
// RULE10 - start requested on a busy bus waits for release, then goes out
// RULE11 - bus stays free 4.7us standard or 1.3us fast before a start
// RULE12 - software checks bus-occupied is clear before requesting start
// RULE13 - transmit-empty is cleared on the clock-line fall after a nack
// RULE14 - a start on the bus clears stop-seen, start-seen and nack flags; the code sets start-seen instead of clearing it
// RULE15 - software polls auto-cleared flags or keeps clears six cycles away
// RULE16 - flags stay set until cleared by software or a hardware clear event
module iusu_serial_unit import iusu_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // two-wire bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // uart pins
  input wire logic uart_rxd,
  output logic uart_txd
);
  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  iusu_state_s st_ff, nxt_st;
  logic [6:0] set_f, clr_f;
  logic wr_en, start_det, stop_det, scl_fall, rx_fall, adv, sending, byte_done, got_nack;
  logic ab_done, rx_w1c;
  logic [7:0] qtr;
  logic [19:0] bit_per, bit_last;
  logic [15:0] ab_val;

  assign wr_en = avs_write && st_ff.ack;
  assign rx_w1c = wr_en && avs_address == REG_STATUS && avs_writedata[F_RX];
  assign start_det = st_ff.scl_s[1] && st_ff.sda_s[2] && !st_ff.sda_s[1];
  assign stop_det = st_ff.scl_s[1] && !st_ff.sda_s[2] && st_ff.sda_s[1];
  assign scl_fall = st_ff.scl_s[2] && !st_ff.scl_s[1];
  assign rx_fall = st_ff.rxd_s[2] && !st_ff.rxd_s[1];
  assign qtr = st_ff.ctl[C_FAST] ? QTR_FAST_CYC : QTR_STD_CYC;
  // a slave holding the clock low stretches the high phase
  assign adv = st_ff.qcnt == 8'h00 && !(st_ff.ph == 2'h2 && !st_ff.scl_s[1])
    && (st_ff.ist == I_START || st_ff.ist == I_BYTE || st_ff.ist == I_STOP);
  assign sending = st_ff.seq != SEQ_DATA || !st_ff.ctl[C_RX];
  assign byte_done = st_ff.ist == I_BYTE && adv && st_ff.ph == 2'h3 && st_ff.bitn == 4'h8;
  assign got_nack = byte_done && sending && st_ff.ackb;
  assign bit_per = st_ff.ctl[C_OS16] ? {st_ff.baud, 4'h0} : {4'h0, st_ff.baud};
  // counter runs down to zero inclusive, so load one less for a bit of exactly bit_per cycles
  assign bit_last = bit_per - 20'h00001;
  assign ab_done = st_ff.ctl[C_AB] && !st_ff.ctl[C_HOLD] && st_ff.ab == A_SYNC && rx_fall
    && st_ff.aedge == 3'h3;
  assign ab_val = st_ff.ctl[C_OS16] ? 16'((st_ff.acnt + AB_RND16) >> AB_SH16)
    : 16'((st_ff.acnt + AB_RND1) >> AB_SH1);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    set_f = '0;
    clr_f = '0;
    nxt_st.ack = (avs_read || avs_write) && !st_ff.ack;
    nxt_st.scl_s = {st_ff.scl_s[1:0], scl_i};
    nxt_st.sda_s = {st_ff.sda_s[1:0], sda_i};
    nxt_st.rxd_s = {st_ff.rxd_s[1:0], uart_rxd};
    // bus monitor; a start and a stop in one cycle cannot happen
    if (start_det) begin
      nxt_st.bus_busy = 1'b1;
      set_f[F_START] = 1'b1;
      clr_f[F_STOP] = 1'b1; // [RULE14]
      clr_f[F_NACK] = 1'b1; // [RULE14]
    end else if (stop_det) begin
      nxt_st.bus_busy = 1'b0;
      set_f[F_STOP] = 1'b1;
      nxt_st.free_cnt = st_ff.ctl[C_FAST] ? TBUF_FAST_CYC : TBUF_STD_CYC; // [RULE11]
    end else if (st_ff.free_cnt != 8'h00) begin
      nxt_st.free_cnt = st_ff.free_cnt - 8'h01;
    end
    if (st_ff.fall_pend && scl_fall) begin
      clr_f[F_TX] = 1'b1; // [RULE13]
      nxt_st.fall_pend = 1'b0;
    end
    // bit timing: clock low, data set, clock released, sample
    if (st_ff.qcnt != 8'h00) begin
      nxt_st.qcnt = st_ff.qcnt - 8'h01;
    end else if (adv) begin
      nxt_st.qcnt = qtr;
      nxt_st.ph = st_ff.ph + 2'h1;
    end
    unique case (st_ff.ist)
      I_IDLE: begin
        nxt_st.scl_low = 1'b0;
        nxt_st.sda_low = 1'b0;
        nxt_st.ctl[C_STOP] = 1'b0;
        if (st_ff.ctl[C_START] && !st_ff.bus_busy && st_ff.free_cnt == 8'h00) begin // [RULE10] [RULE11]
          nxt_st.ist = I_START;
          nxt_st.ph = 2'h0;
          nxt_st.qcnt = qtr;
          nxt_st.scl_low = 1'b1;
        end
      end
      I_START: if (adv) begin
        unique case (st_ff.ph)
          2'h0: nxt_st.sda_low = 1'b0;
          2'h1: nxt_st.scl_low = 1'b0;
          2'h2: nxt_st.sda_low = 1'b1;
          2'h3: begin
            nxt_st.scl_low = 1'b1;
            nxt_st.ist = I_BYTE;
            nxt_st.seq = SEQ_A1;
            nxt_st.bitn = 4'h0;
            nxt_st.nack_pend = 1'b0;
            nxt_st.sh = st_ff.ctl[C_TEN] ? {TEN_BIT_HDR, st_ff.saddr[9:8], st_ff.ctl[C_RX]}
              : {st_ff.saddr[6:0], st_ff.ctl[C_RX]};
          end
        endcase
      end
      I_BYTE: if (adv) begin
        unique case (st_ff.ph)
          2'h0: begin
            if (st_ff.bitn == 4'h8) begin
              nxt_st.sda_low = !sending && !st_ff.ctl[C_STOP];
            end else begin
              nxt_st.sda_low = sending && !st_ff.sh[7];
            end
          end
          2'h1: nxt_st.scl_low = 1'b0;
          2'h2: begin
            if (st_ff.bitn == 4'h8) begin
              nxt_st.ackb = st_ff.sda_s[1];
            end else begin
              nxt_st.sh = {st_ff.sh[6:0], st_ff.sda_s[1]};
            end
          end
          2'h3: begin
            nxt_st.scl_low = 1'b1;
            nxt_st.bitn = st_ff.bitn + 4'h1;
            if (byte_done) begin
              nxt_st.bitn = 4'h0;
              nxt_st.sda_low = 1'b0;
              if (!sending) begin
                nxt_st.rxdata = st_ff.sh;
                set_f[F_RX] = 1'b1;
                nxt_st.ist = st_ff.ctl[C_STOP] ? I_STOP : I_BYTE;
              end else if (st_ff.ackb) begin
                set_f[F_NACK] = 1'b1;
                nxt_st.nack_pend = 1'b1;
                nxt_st.fall_pend = 1'b1;
                nxt_st.ctl[C_START] = 1'b0;
                if (st_ff.ctl[C_START] && !st_ff.ctl[C_STOP]) begin
                  clr_f[F_TX] = 1'b1; // [RULE9]
                end
                nxt_st.ist = I_HOLD;
              end else if (st_ff.seq == SEQ_A1 && st_ff.ctl[C_TEN]) begin
                // the low address byte always follows, also after a repeated start
                nxt_st.seq = SEQ_A2; // [RULE1] [RULE2]
                nxt_st.sh = st_ff.saddr[7:0];
              end else if (st_ff.seq != SEQ_DATA) begin
                nxt_st.seq = SEQ_DATA;
                nxt_st.ctl[C_START] = 1'b0;
                if (!st_ff.ctl[C_RX]) begin
                  set_f[F_TX] = 1'b1;
                  nxt_st.ist = I_HOLD;
                end
              end else begin
                nxt_st.ist = I_HOLD;
              end
            end
          end
        endcase
      end
      I_HOLD: begin
        nxt_st.ph = 2'h0;
        nxt_st.qcnt = qtr;
        if (st_ff.ctl[C_STOP]) begin
          nxt_st.ist = I_STOP;
        end else if (st_ff.ctl[C_START]) begin
          nxt_st.ist = I_START;
        end else if (!st_ff.nack_pend && sending && st_ff.tx_loaded) begin
          nxt_st.ist = I_BYTE;
          nxt_st.sh = st_ff.i2c_tx;
          nxt_st.tx_loaded = 1'b0;
          set_f[F_TX] = 1'b1;
        end
      end
      I_STOP: if (adv) begin
        unique case (st_ff.ph)
          2'h0: nxt_st.sda_low = 1'b1;
          2'h1: nxt_st.scl_low = 1'b0;
          2'h2: nxt_st.sda_low = 1'b1;
          2'h3: begin
            nxt_st.sda_low = 1'b0;
            nxt_st.ist = I_IDLE;
            nxt_st.ctl[C_STOP] = 1'b0;
            nxt_st.nack_pend = 1'b0;
          end
        endcase
      end
      default: nxt_st.ist = I_IDLE;
    endcase
    // uart transmitter; a break only starts from idle so a running frame keeps its stop bit
    unique case (st_ff.ust)
      U_IDLE: begin
        nxt_st.txd = 1'b1;
        nxt_st.ucnt = bit_last;
        nxt_st.ubit = 4'h0;
        if (st_ff.ctl[C_BRK]) begin
          nxt_st.ust = U_BREAK; // [RULE4]
          nxt_st.txd = 1'b0;
        end else if (st_ff.utx_loaded) begin
          nxt_st.ust = U_DATA;
          nxt_st.ush = {1'b1, st_ff.uart_tx, 2'h1};
          nxt_st.utx_loaded = 1'b0;
          set_f[F_UTX] = 1'b1;
        end
      end
      U_DATA: begin
        if (st_ff.ucnt != 20'h00000) begin
          nxt_st.ucnt = st_ff.ucnt - 20'h00001;
        end else if (st_ff.ubit == FRAME_LAST) begin
          nxt_st.ust = U_IDLE;
        end else begin
          nxt_st.ubit = st_ff.ubit + 4'h1;
          nxt_st.ush = {1'b1, st_ff.ush[10:1]};
          nxt_st.txd = st_ff.ush[1]; // [RULE4]
          nxt_st.ucnt = bit_last;
        end
      end
      U_BREAK: begin
        if (st_ff.ucnt != 20'h00000) begin
          nxt_st.ucnt = st_ff.ucnt - 20'h00001;
        end else if (st_ff.ubit == BRK_LAST) begin
          nxt_st.ust = U_DATA;
          nxt_st.ubit = 4'h0;
          nxt_st.ucnt = bit_last;
          nxt_st.ush = {1'b1, SYNC_CHAR, 2'h1};
          nxt_st.txd = 1'b1;
          nxt_st.ctl[C_BRK] = 1'b0;
        end else begin
          nxt_st.ubit = st_ff.ubit + 4'h1;
          nxt_st.ucnt = bit_last;
        end
      end
      default: nxt_st.ust = U_IDLE;
    endcase
    // baud detection: long low, then eight bit times across the synch field
    if (st_ff.ctl[C_AB] && !st_ff.ctl[C_HOLD]) begin
      unique case (st_ff.ab)
        A_IDLE: begin
          nxt_st.acnt = 20'h00000;
          if (!st_ff.rxd_s[1]) begin
            nxt_st.ab = A_LOW;
          end
        end
        A_LOW: begin
          if (st_ff.rxd_s[1]) begin
            nxt_st.ab = st_ff.acnt >= BRK_MIN_CYC ? A_HIGH : A_IDLE;
          end else if (st_ff.acnt != 20'hFFFFF) begin
            nxt_st.acnt = st_ff.acnt + 20'h00001;
          end
        end
        A_HIGH: begin
          nxt_st.acnt = 20'h00000;
          nxt_st.aedge = 3'h0;
          if (rx_fall) begin
            nxt_st.ab = A_SYNC;
          end
        end
        A_SYNC: begin
          nxt_st.acnt = st_ff.acnt + 20'h00001;
          if (ab_done) begin
            nxt_st.ab = A_IDLE;
            nxt_st.baud = ab_val; // [RULE6] [RULE7]
            set_f[F_BRK] = 1'b1; // [RULE8]
          end else if (rx_fall) begin
            nxt_st.aedge = st_ff.aedge + 3'h1;
          end else if (st_ff.acnt == 20'hFFFFF) begin
            nxt_st.ab = A_IDLE;
          end
        end
      endcase
    end else begin
      nxt_st.ab = A_IDLE;
    end
    // held in reset by software: engines idle, pins released
    if (st_ff.ctl[C_HOLD]) begin
      nxt_st.ist = I_IDLE;
      nxt_st.ust = U_IDLE;
      nxt_st.scl_low = 1'b0;
      nxt_st.sda_low = 1'b0;
      nxt_st.txd = 1'b1;
      nxt_st.tx_loaded = 1'b0;
      nxt_st.utx_loaded = 1'b0;
    end
    // ----------------------------------------
    // register access
    // ----------------------------------------
    if (avs_read && !st_ff.ack) begin
      unique case (avs_address)
        REG_CTRL: nxt_st.rdata = {23'h000000, st_ff.ctl};
        REG_ADDR: nxt_st.rdata = {22'h000000, st_ff.saddr};
        REG_I2C_DATA: nxt_st.rdata = {24'h000000, st_ff.i2c_tx};
        REG_UART_DATA: nxt_st.rdata = {24'h000000, st_ff.uart_tx};
        REG_STATUS: nxt_st.rdata = {25'h0000000, st_ff.flags};
        REG_MASK: nxt_st.rdata = {25'h0000000, st_ff.mask};
        REG_STATE: nxt_st.rdata = {16'h0000, st_ff.rxdata, 6'h00, st_ff.ust != U_IDLE, st_ff.bus_busy};
        REG_BAUD: nxt_st.rdata = {16'h0000, st_ff.baud};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
    if (wr_en) begin
      unique case (avs_address)
        REG_CTRL: nxt_st.ctl = avs_writedata[8:0];
        REG_ADDR: nxt_st.saddr = avs_writedata[9:0];
        REG_I2C_DATA: begin
          nxt_st.i2c_tx = avs_writedata[7:0];
          nxt_st.tx_loaded = 1'b1;
          clr_f[F_TX] = 1'b1;
        end
        REG_UART_DATA: begin
          nxt_st.uart_tx = avs_writedata[7:0];
          nxt_st.utx_loaded = 1'b1;
          clr_f[F_UTX] = 1'b1;
        end
        REG_STATUS: clr_f = clr_f | avs_writedata[6:0];
        REG_MASK: nxt_st.mask = avs_writedata[6:0];
        REG_BAUD: nxt_st.baud = avs_writedata[15:0];
        default: nxt_st.mask = st_ff.mask;
      endcase
    end
    // a set in the same cycle as a clear wins
    nxt_st.flags = (st_ff.flags & ~clr_f) | set_f; // [RULE16]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.flags <= FLAGS_RST;
      st_ff.baud <= BAUD_RST;
      st_ff.txd <= 1'b1;
      st_ff.scl_s <= SYNC_RST;
      st_ff.sda_s <= SYNC_RST;
      st_ff.rxd_s <= SYNC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st_ff.ack;
  assign avs_readdata = st_ff.rdata;
  assign irq = |(st_ff.flags & st_ff.mask);
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = st_ff.scl_low;
  assign sda_oe = st_ff.sda_low;
  assign uart_txd = st_ff.txd;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ten_bit_seq_a: // [RULE1]
    assert property (byte_done && sending && !st_ff.ackb && st_ff.seq == SEQ_A1 && st_ff.ctl[C_TEN]
      |=> st_ff.seq == SEQ_A2 && st_ff.ist == I_BYTE && st_ff.sh == st_ff.saddr[7:0])
    else $error("second address byte not sent");
  rx_after_addr_a: // [RULE2]
    assert property ($rose(st_ff.flags[F_RX]) |-> $past(st_ff.seq) == SEQ_DATA)
    else $error("receive flag before address done");
  stop_bit_a: // [RULE4]
    assert property (st_ff.ust == U_DATA && st_ff.ubit == FRAME_LAST |-> st_ff.txd)
    else $error("stop bit not high");
  brk_entry_a: // [RULE4]
    assert property (st_ff.ust != U_BREAK && nxt_st.ust == U_BREAK |-> st_ff.ust == U_IDLE)
    else $error("break cut a frame");
  baud_write_a: // [RULE6]
    assert property (ab_done |=> st_ff.baud == $past(ab_val))
    else $error("divider not updated");
  os16_two_a: // [RULE7]
    assert property (ab_done && st_ff.ctl[C_OS16] && st_ff.acnt >= 20'h000C0 && st_ff.acnt < 20'h00140
      |=> st_ff.baud == 16'h0002)
    else $error("divider two misreported");
  brk_flag_a: // [RULE8]
    assert property (ab_done |=> st_ff.flags[F_BRK])
    else $error("break flag not set");
  nack_txflag_a: // [RULE9]
    assert property (got_nack && st_ff.ctl[C_START] && !st_ff.ctl[C_STOP] |=> !st_ff.flags[F_TX])
    else $error("transmit flag kept after nack");
  start_wait_a: // [RULE10]
    assert property (st_ff.ist == I_IDLE && nxt_st.ist == I_START |-> !st_ff.bus_busy && st_ff.free_cnt == 8'h00)
    else $error("start on busy bus");
  free_time_a: // [RULE11]
    assert property (stop_det && !st_ff.ctl[C_FAST] |=> st_ff.free_cnt == TBUF_STD_CYC)
    else $error("bus free time not loaded");
  fall_clear_a: // [RULE13]
    assert property (st_ff.fall_pend && scl_fall |=> !st_ff.flags[F_TX] && !st_ff.fall_pend)
    else $error("transmit flag kept after clock fall");
  start_clear_a: // [RULE14]
    assert property (start_det |=> !st_ff.flags[F_STOP] && !st_ff.flags[F_NACK] && st_ff.flags[F_START])
    else $error("flags not cleared by start");
  sticky_a: // [RULE16]
    assert property ($fell(st_ff.flags[F_RX]) |-> $past(rx_w1c))
    else $error("receive flag dropped by itself");
endmodule

// ===== verification/iusu_bus_slave.sv
// two-wire bus slave and competing-master model for the serial unit bench
`timescale 1ns/1ns
module iusu_bus_slave (
  // clock and bus lines
  input wire logic ref_clk,
  input wire logic scl,
  input wire logic sda,
  // behaviour control
  input wire logic hold_bus,
  input wire logic [2:0] nack_at,
  // open-drain pull and captured address bytes
  output logic sda_pull,
  output logic [7:0] byte0,
  output logic [7:0] byte1
);
  logic scl_q, sda_q, ack_drv;
  logic [3:0] bitc;
  logic [2:0] idx;
  logic [7:0] sh;
  // sda held low while scl idles high looks like another master owning the bus
  assign sda_pull = ack_drv | hold_bus;
  initial begin
    {scl_q, sda_q, ack_drv, bitc, idx, sh, byte0, byte1} = '0;
  end
  // ----------------------------------------
  // framing: start resets count, ack only the two address bytes
  // ----------------------------------------
  always @(posedge ref_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && sda_q && !sda) begin
      bitc <= 4'h0;
      idx <= 3'h0;
    end else if (scl && !scl_q) begin
      sh <= {sh[6:0], sda};
      bitc <= bitc + 4'h1;
    end else if (!scl && scl_q) begin
      if (bitc == 4'h8) begin
        ack_drv <= (idx < 3'h2) && (idx != nack_at);
        if (idx == 3'h0) byte0 <= sh;
        if (idx == 3'h1) byte1 <= sh;
      end
      if (bitc == 4'h9) begin
        ack_drv <= 1'b0;
        bitc <= 4'h0;
        idx <= idx + 3'h1;
      end
    end
  end
endmodule

// ===== verification/tb.sv
// self-checking bench for the serial unit
`timescale 1ns/1ns
module tb;
  import iusu_pkg::*;
  localparam logic [31:0] CFG = (32'h1 << C_TEN) | (32'h1 << C_FAST);
  logic ref_clk, rst, avs_read, avs_write, hold_bus, uart_rxd;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, last_rd;
  logic avs_waitrequest, irq, scl_oe, sda_oe, uart_txd, sda_pull;
  logic [2:0] nack_at;
  logic [7:0] byte0, byte1;
  logic [9:0] addr;
  wire scl = !scl_oe;
  wire sda = !(sda_oe | sda_pull);
  int n_errors, checks_done, cyc, n1, n2, gap, bt;
  logic [31:0] q_exp[$], q_msk[$];
  iusu_serial_unit dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .uart_rxd(uart_rxd), .uart_txd(uart_txd));
  iusu_bus_slave u_slave (.ref_clk(ref_clk), .scl(scl), .sda(sda), .hold_bus(hold_bus), .nack_at(nack_at),
    .sda_pull(sda_pull), .byte0(byte0), .byte1(byte1));
  // ----------------------------------------
  // checking, bus tasks and result monitor
  // ----------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one idle edge first, so back-to-back calls never assign a strobe twice in one step
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++t < 20);
    if (avs_waitrequest !== 1'b0) n_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [31:0] m, logic [31:0] e);
    q_msk.push_back(m);
    q_exp.push_back(e & m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic poll(logic [5:0] a, int b);
    int t;
    t = 0;
    do rd(a, 32'h0, 32'h0); while (last_rd[b] !== 1'b1 && ++t < 1000);
    check("poll flag", {31'h0, last_rd[b]}, 32'h1);
  endtask
  task automatic low_run(output int n);
    int t;
    t = 0;
    n = 0;
    while (uart_txd !== 1'b0 && t < 3000) begin @(negedge ref_clk); t++; end
    while (uart_txd === 1'b0 && n < 3000) begin @(negedge ref_clk); n++; end
  endtask
  task automatic send_sync(int t);
    logic [9:0] fr;
    fr = {1'b1, SYNC_CHAR, 1'b0};
    uart_rxd <= 1'b0;
    repeat (2100) @(posedge ref_clk);
    for (int i = -1; i < 10; i++) begin
      uart_rxd <= (i < 0) ? 1'b1 : fr[i];
      repeat (t) @(posedge ref_clk);
    end
    repeat (40) @(posedge ref_clk);
  endtask
  always @(negedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && q_exp.size() > 0) begin
      last_rd <= avs_readdata;
      if (q_msk[0] != 32'h0) check("readdata", avs_readdata & q_msk[0], q_exp[0]);
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata, hold_bus, nack_at} = '0;
    {rst, uart_rxd, cyc, n_errors, checks_done} = '0;
    rst = 1'b1;
    uart_rxd = 1'b1;
    void'($urandom(94149));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_STATUS, 32'h7F, 32'(FLAGS_RST));
    rd(REG_BAUD, 32'hFFFF, 32'(BAUD_RST));
    rd(REG_MASK, 32'h7F, 32'h0);
    rd(6'h3C, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    addr = 10'($urandom);
    nack_at <= 3'h1;
    hold_bus <= 1'b1;
    bus(1'b1, REG_ADDR, 32'(addr));
    bus(1'b1, REG_CTRL, CFG | 32'h1);
    repeat (200) @(posedge ref_clk);
    rd(REG_STATE, 32'h1, 32'h1);
    rd(REG_CTRL, 32'h1, 32'h1);
    hold_bus <= 1'b0;
    gap = 0;
    @(posedge sda);
    while (sda === 1'b1 && gap < 1000) begin @(negedge ref_clk); gap++; end
    check("bus free time", 32'(gap >= int'(TBUF_FAST_CYC)), 32'h1);
    check("start after release", 32'(gap < 1000), 32'h1);
    poll(REG_STATUS, F_NACK);
    rd(REG_STATUS, 32'h1 << F_TX, 32'h0);
    check("address header", 32'(byte0), 32'({TEN_BIT_HDR, addr[9:8], 1'b0}));
    check("address low", 32'(byte1), 32'(addr[7:0]));
    nack_at <= 3'h7;
    bus(1'b1, REG_CTRL, CFG | 32'h9);
    poll(REG_STATUS, F_RX);
    check("restart header", 32'(byte0), 32'({TEN_BIT_HDR, addr[9:8], 1'b1}));
    check("restart low", 32'(byte1), 32'(addr[7:0]));
    rd(REG_STATUS, 32'h18, 32'h1 << F_START);
    bus(1'b1, REG_CTRL, CFG | 32'hA);
    poll(REG_STATUS, F_STOP);
    bus(1'b1, REG_STATUS, 32'h1 << F_START);
    rd(REG_STATE, 32'h1, 32'h0);
    bus(1'b1, REG_CTRL, CFG | 32'h1);
    poll(REG_STATUS, F_START);
    rd(REG_STATUS, 32'h1 << F_STOP, 32'h0);
    bus(1'b1, REG_CTRL, CFG | 32'h2);
    $display("test two-wire done");
    rd(REG_STATE, 32'h2, 32'h0);
    bt = 3 + int'($urandom % 4);
    bus(1'b1, REG_BAUD, 32'(bt));
    bus(1'b1, REG_UART_DATA, 32'h0);
    fork
      begin low_run(n1); low_run(n2); end
      begin repeat (12) @(posedge ref_clk); bus(1'b1, REG_CTRL, 32'h1 << C_BRK); end
    join
    check("char low run", 32'(n1), 32'(9 * bt));
    check("break low run", 32'(n2), 32'(13 * bt));
    $display("test break done");
    bus(1'b1, REG_MASK, 32'h1 << F_BRK);
    for (int os = 1; os >= 0; os--) begin
      bt = os ? 32 : 10 + int'($urandom % 20);
      bus(1'b1, REG_CTRL, (32'(os) << C_OS16) | (32'h1 << C_AB));
      send_sync(bt);
      rd(REG_BAUD, 32'hFFFF, os ? 32'h2 : 32'(bt));
      rd(REG_STATUS, 32'h1 << F_BRK, 32'h1 << F_BRK);
      @(negedge ref_clk);
      check("irq raised", {31'h0, irq}, 32'h1);
      bus(1'b1, REG_STATUS, 32'h1 << F_BRK);
      rd(REG_STATUS, 32'h1 << F_BRK, 32'h0);
      @(negedge ref_clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
    $display("test autobaud done");
    end_sim();
  end
endmodule
